// [rtl/pbsp_port.sv]
// pipelined burst sram port: strobes, burst counter, byte writes, output control
// Operation
// - clocked inputs and read data pass through registers; output enable and sleep act on the pins without a clock
// - selected only when all three selects active
// - low output enable drives, high floats
// - first read after deselect keeps outputs floating
// - low advance steps the burst address
// - processor strobe loads address and burst counter
// - controller strobe loads address and burst counter
// - both strobes low: processor strobe wins
// - processor strobe ignored while first select high
// - sleep input pauses activity, keeps contents
// - data pins captured on clock as inputs
// - read data from previous edge's address
// - burst order strap, static, low is linear
// - two-bit wrapping counter generates burst addresses
// - byte write needs enable and lane select low
// - global write writes all four bytes
// - interleaved order xors start with count
// - linear order counts up modulo four
// - processor write takes two cycles
// - controller write completes in one cycle
`timescale 1ns/1ns
module pbsp_port #(
  parameter int WORDS = 65536             // array depth
) (
  // clock and reset
  input  wire logic                           core_clk_i,
  input  wire logic                           reset_i,
  // address and strobes
  input  wire logic [pbsp_pkg::ADDR_W-1:0]    addr_i,
  input  wire logic                           proc_addr_strobe_n_i,
  input  wire logic                           ctrl_addr_strobe_n_i,
  input  wire logic                           burst_step_n_i,
  // chip selects
  input  wire logic                           chip_sel_first_n_i,
  input  wire logic                           chip_sel_second_i,
  input  wire logic                           chip_sel_third_n_i,
  // write controls
  input  wire logic                           all_bytes_write_n_i,
  input  wire logic                           byte_write_en_n_i,
  input  wire logic [pbsp_pkg::LANES-1:0]     byte_lane_sel_n_i,
  // static and asynchronous controls
  input  wire logic                           out_en_n_i,
  input  wire logic                           sleep_req_i,
  input  wire logic                           burst_order_i,
  // data pins
  input  wire logic [pbsp_pkg::DATA_W-1:0]    dq_i,
  output logic      [pbsp_pkg::DATA_W-1:0]    dq_o,
  output logic                                dq_oe_o
);
  import pbsp_pkg::*;

  // all sequential state of the port except the array and the write fifo
  typedef struct packed {
    logic                sel_r;           // part currently selected
    logic [ADDR_W-1:0]   addr_r;          // captured address
    logic [BURST_W-1:0]  start_r;         // first burst position
    logic [BURST_W-1:0]  cnt_r;           // steps taken in the burst
    logic                rd_v_r;          // read data held in output register
    logic                mask_r;          // first read after deselect
    logic [DATA_W-1:0]   dout_r;          // output data register
    logic [DATA_W-1:0]   din_r;           // captured write data
    logic                wv_r;            // write staged for the fifo
    logic [ADDR_W-1:0]   wa_r;            // staged write address
    logic [LANES-1:0]    wm_r;            // staged lane mask
  } pbsp_st_type;

  pbsp_st_type       st_r;                // registered state
  pbsp_st_type       st_nxt;              // next state
  logic [DATA_W-1:0] mem_r [WORDS];       // storage array, no reset
  logic              ce_ok;               // all selects active
  logic              p_go;                // processor strobe recognised
  logic              c_go;                // controller strobe recognised
  logic [LANES-1:0]  lane_mask;           // lanes the write controls ask for
  logic              wr_ctrl;             // some write asked for
  logic              wr_seen;             // write cycle on the pins now
  logic              fifo_in_ready;       // staging fifo has room
  logic              fifo_out_valid;      // a staged write waits
  logic [WQ_W-1:0]   fifo_out_data;       // oldest staged write
  logic              stage_mv;            // staged write enters the fifo
  logic              drain;               // fifo head written to the array
  pbsp_acc_type      acc;                 // access chosen this cycle
  logic [ADDR_W-1:0] acc_addr;            // address of that access
  logic [BURST_W-1:0] cnt_step;           // counter after optional step

  // burst position from start and step count
  function automatic logic [BURST_W-1:0] burst_pos(input logic [BURST_W-1:0] start,
                                                   input logic [BURST_W-1:0] cnt,
                                                   input logic order);
    if (order == ORDER_LINEAR) begin
      burst_pos = start + cnt;
    end else begin
      burst_pos = start ^ cnt;
    end
  endfunction

  // overlay the enabled lanes of a newer write onto a word
  function automatic logic [DATA_W-1:0] merge(input logic [DATA_W-1:0] old_w,
                                              input logic [DATA_W-1:0] new_w,
                                              input logic [LANES-1:0] m);
    merge = old_w;
    for (int i = 0; i < LANES; i++) begin
      if (m[i]) begin
        merge[i*8 +: 8] = new_w[i*8 +: 8];
      end
    end
  endfunction

  // select and strobe decode
  assign ce_ok = !chip_sel_first_n_i && chip_sel_second_i && !chip_sel_third_n_i;
  assign p_go  = !proc_addr_strobe_n_i && !chip_sel_first_n_i;
  assign c_go  = !ctrl_addr_strobe_n_i && !p_go;
  // global write overrides the byte controls
  assign lane_mask = !all_bytes_write_n_i ? LANE_ALL :
                     (!byte_write_en_n_i ? ~byte_lane_sel_n_i : LANE_NONE);
  assign wr_ctrl = (lane_mask != LANE_NONE);
  // write controls beside a processor strobe do not count as a write
  assign wr_seen = st_r.sel_r && wr_ctrl && !p_go;

  // pins drive only a valid, unmasked read while enabled
  assign dq_o    = st_r.dout_r;
  assign dq_oe_o = !out_en_n_i && st_r.rd_v_r && !st_r.mask_r &&
                   !wr_seen && !sleep_req_i;

  // staged writes move on and drain only while awake
  assign stage_mv = st_r.wv_r && fifo_in_ready && !sleep_req_i;
  assign drain    = fifo_out_valid && !sleep_req_i;

  pbsp_fifo #(
    .WIDTH (WQ_W),
    .DEPTH (FIFO_DEPTH)
  ) u_wq (
    .core_clk_i  (core_clk_i),
    .reset_i     (reset_i),
    .in_valid_i  (st_r.wv_r && !sleep_req_i),
    .in_ready_o  (fifo_in_ready),
    .in_data_i   ({st_r.wa_r, st_r.din_r, st_r.wm_r}),
    .out_valid_o (fifo_out_valid),
    .out_ready_i (!sleep_req_i),
    .out_data_o  (fifo_out_data)
  );

  // next-state logic: strobes, burst stepping, read and write staging
  always_comb begin
    st_nxt   = st_r;
    acc      = ACC_IDLE;
    cnt_step = st_r.cnt_r;
    acc_addr = {st_r.addr_r[ADDR_W-1:BURST_W],
                burst_pos(st_r.start_r, st_r.cnt_r, burst_order_i)};
    if (stage_mv) begin
      st_nxt.wv_r = 1'b0;
    end
    // sleep freezes the port; contents and burst state are kept
    if (!sleep_req_i) begin
      st_nxt.rd_v_r = 1'b0;
      st_nxt.mask_r = 1'b0;
      if (p_go || c_go) begin
        if (ce_ok) begin
          // new access: full address, low bits as burst start, counter cleared
          st_nxt.addr_r  = addr_i;
          st_nxt.start_r = addr_i[BURST_W-1:0];
          st_nxt.cnt_r   = CNT_ZERO;
          st_nxt.sel_r   = 1'b1;
          st_nxt.mask_r  = !st_r.sel_r;
          acc_addr       = addr_i;
          // controller write is done here; processor strobe always reads first
          acc = (c_go && wr_ctrl) ? ACC_WRITE : ACC_READ;
        end else begin
          st_nxt.sel_r = 1'b0;
        end
      end else if (st_r.sel_r) begin
        // continuation: step first, then access the new position
        if (!burst_step_n_i) begin
          cnt_step = st_r.cnt_r + CNT_ONE;
        end
        st_nxt.cnt_r = cnt_step;
        acc_addr = {st_r.addr_r[ADDR_W-1:BURST_W],
                    burst_pos(st_r.start_r, cnt_step, burst_order_i)};
        acc = wr_ctrl ? ACC_WRITE : ACC_READ;
      end
      if (acc == ACC_READ) begin
        // youngest writes win: array, then fifo head, then stage
        st_nxt.rd_v_r = 1'b1;
        st_nxt.dout_r = mem_r[acc_addr];
        if (fifo_out_valid && fifo_out_data[WQ_W-1 -: ADDR_W] == acc_addr) begin
          st_nxt.dout_r = merge(st_nxt.dout_r, fifo_out_data[LANES +: DATA_W],
                                fifo_out_data[LANES-1:0]);
        end
        if (st_r.wv_r && st_r.wa_r == acc_addr) begin
          st_nxt.dout_r = merge(st_nxt.dout_r, st_r.din_r, st_r.wm_r);
        end
      end
      // a write finding the stage still blocked is lost
      if (acc == ACC_WRITE && (!st_r.wv_r || stage_mv)) begin
        st_nxt.wv_r  = 1'b1;
        st_nxt.wa_r  = acc_addr;
        st_nxt.din_r = dq_i;
        st_nxt.wm_r  = lane_mask;
      end
    end
  end

  // state register
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // array write from the fifo head, one word per cycle
  always_ff @(posedge core_clk_i) begin
    if (drain) begin
      mem_r[fifo_out_data[WQ_W-1 -: ADDR_W]] <= merge(mem_r[fifo_out_data[WQ_W-1 -: ADDR_W]],
                                                      fifo_out_data[LANES +: DATA_W],
                                                      fifo_out_data[LANES-1:0]);
    end
  end

  // checks
  property p_desel;
    @(posedge core_clk_i) disable iff (reset_i)
      ((p_go || c_go) && !ce_ok && !sleep_req_i) |=> !st_r.sel_r && !dq_oe_o;
  endproperty
  a_desel: assert property (p_desel) else $error("strobe with inactive select kept part selected");

  property p_oe_high;
    @(posedge core_clk_i) disable iff (reset_i)
      out_en_n_i |-> !dq_oe_o;
  endproperty
  a_oe_high: assert property (p_oe_high) else $error("pins driven with output enable high");

  property p_first_mask;
    @(posedge core_clk_i) disable iff (reset_i)
      (!st_r.sel_r && p_go && ce_ok && !sleep_req_i) |=> !dq_oe_o;
  endproperty
  a_first_mask: assert property (p_first_mask) else $error("first read after deselect drove");

  property p_step;
    @(posedge core_clk_i) disable iff (reset_i)
      (st_r.sel_r && !p_go && !c_go && !burst_step_n_i && !sleep_req_i)
        |=> st_r.cnt_r == $past(st_r.cnt_r) + CNT_ONE;
  endproperty
  a_step: assert property (p_step) else $error("advance did not step the burst counter");

  property p_load;
    @(posedge core_clk_i) disable iff (reset_i)
      ((p_go || c_go) && ce_ok && !sleep_req_i)
        |=> st_r.addr_r == $past(addr_i) && st_r.cnt_r == CNT_ZERO;
  endproperty
  a_load: assert property (p_load) else $error("strobe did not load address and counter");

  property p_proc_wins;
    @(posedge core_clk_i) disable iff (reset_i)
      (p_go && !ctrl_addr_strobe_n_i && ce_ok && wr_ctrl && !sleep_req_i)
        |=> st_r.rd_v_r && st_r.addr_r == $past(addr_i);
  endproperty
  a_proc_wins: assert property (p_proc_wins) else $error("controller write taken beside processor strobe");

  property p_proc_ignored;
    @(posedge core_clk_i) disable iff (reset_i)
      (chip_sel_first_n_i && ctrl_addr_strobe_n_i && !sleep_req_i)
        |=> st_r.sel_r == $past(st_r.sel_r) && st_r.start_r == $past(st_r.start_r);
  endproperty
  a_proc_ignored: assert property (p_proc_ignored) else $error("processor strobe acted with select high");

  property p_global;
    @(posedge core_clk_i) disable iff (reset_i)
      (c_go && ce_ok && !all_bytes_write_n_i && !st_r.wv_r && !sleep_req_i)
        |=> st_r.wv_r && st_r.wm_r == LANE_ALL && st_r.din_r == $past(dq_i);
  endproperty
  a_global: assert property (p_global) else $error("global write did not take all lanes");

  property p_no_write;
    @(posedge core_clk_i) disable iff (reset_i)
      (all_bytes_write_n_i && byte_write_en_n_i && !st_r.wv_r)
        |=> !st_r.wv_r;
  endproperty
  a_no_write: assert property (p_no_write) else $error("write staged without byte write enable");

  property p_latency;
    @(posedge core_clk_i) disable iff (reset_i)
      (st_r.sel_r && !p_go && !c_go && !wr_ctrl && !sleep_req_i && !out_en_n_i)
        ##1 (!wr_seen && !out_en_n_i && !sleep_req_i) |-> dq_oe_o;
  endproperty
  a_latency: assert property (p_latency) else $error("continued read not driven next cycle");
endmodule

// [rtl/pbsp_pkg.sv]
// shared constants and types for the pipelined burst sram port
package pbsp_pkg;
  // array geometry
  localparam int ADDR_W  = 16;
  localparam int DATA_W  = 32;
  localparam int LANES   = 4;
  localparam int BURST_W = 2;
  localparam int FIFO_DEPTH = 16;
  // write staging word: address, data and lane mask
  localparam int WQ_W = ADDR_W + DATA_W + LANES;
  // lane masks
  localparam logic [LANES-1:0] LANE_ALL  = 4'hF;
  localparam logic [LANES-1:0] LANE_NONE = 4'h0;
  // burst counter values
  localparam logic [BURST_W-1:0] CNT_ZERO = 2'h0;
  localparam logic [BURST_W-1:0] CNT_ONE  = 2'h1;
  // burst order strap level that selects linear order
  localparam logic ORDER_LINEAR = 1'b0;
  // reset values
  localparam logic [ADDR_W-1:0] ADDR_RST = 16'h0000;
  localparam logic [DATA_W-1:0] DATA_RST = 32'h0000_0000;

  // kind of array access decided in a cycle
  typedef enum logic [1:0] {
    ACC_IDLE  = 2'b00,
    ACC_READ  = 2'b01,
    ACC_WRITE = 2'b10
  } pbsp_acc_type;
endpackage

// [rtl/pbsp_fifo.sv]
// parameterised valid/ready fifo used to stage array writes
`timescale 1ns/1ns
module pbsp_fifo #(
  parameter int WIDTH = 52,
  parameter int DEPTH = 16
) (
  // clock and reset
  input  wire logic             core_clk_i,
  input  wire logic             reset_i,
  // filling side
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  // draining side
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic [WIDTH-1:0]      out_data_o
);
  localparam int PW = $clog2(DEPTH);

  // pointers carry one extra bit so full and empty are told apart
  typedef struct packed {
    logic [PW:0] wr_ptr_r;
    logic [PW:0] rd_ptr_r;
  } pbsp_fifo_st_type;

  pbsp_fifo_st_type st_r;                 // registered pointers
  pbsp_fifo_st_type st_nxt;               // next pointers
  logic [WIDTH-1:0] mem_r [DEPTH];        // storage, no reset needed
  logic             full;                 // all slots taken
  logic             empty;                // nothing stored
  logic             push;                 // accepted write
  logic             pop;                  // accepted read

  assign full  = (st_r.wr_ptr_r[PW] != st_r.rd_ptr_r[PW]) &&
                 (st_r.wr_ptr_r[PW-1:0] == st_r.rd_ptr_r[PW-1:0]);
  assign empty = (st_r.wr_ptr_r == st_r.rd_ptr_r);
  assign in_ready_o  = !full;
  assign out_valid_o = !empty;
  assign push = in_valid_i && !full;
  assign pop  = out_ready_i && !empty;
  // head comes straight from storage; a show-ahead fifo saves a cycle
  assign out_data_o = mem_r[st_r.rd_ptr_r[PW-1:0]];

  // pointer update
  always_comb begin
    st_nxt = st_r;
    if (push) begin
      st_nxt.wr_ptr_r = st_r.wr_ptr_r + 1'b1;
    end
    if (pop) begin
      st_nxt.rd_ptr_r = st_r.rd_ptr_r + 1'b1;
    end
  end

  // state register
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // storage write
  always_ff @(posedge core_clk_i) begin
    if (push) begin
      mem_r[st_r.wr_ptr_r[PW-1:0]] <= in_data_i;
    end
  end
endmodule

// [test/pbsp_bus_model.sv]
// bus master model: drives the port's bus and resolves the shared data pins
`timescale 1ns/1ns
module pbsp_bus_model (
  // clock and port outputs
  input  wire logic                        core_clk_i,
  input  wire logic [pbsp_pkg::DATA_W-1:0] dq_o,
  input  wire logic                        dq_oe_o,
  // strobes {proc_n, ctrl_n, step_n} and selects {first_n, second, third_n}
  output logic [pbsp_pkg::ADDR_W-1:0]      addr_o,
  output logic [2:0]                       strb_o,
  output logic [2:0]                       sel_o,
  // write controls {all_n, byte_en_n, lane_n} and {oe_n, sleep, order}
  output logic [5:0]                       wr_o,
  output logic [2:0]                       mode_o,
  // level seen on the data pins
  output logic [pbsp_pkg::DATA_W-1:0]      dq_line_o
);
  import pbsp_pkg::*;
  logic [DATA_W-1:0] drv_d;         // write data put on the pins
  logic              drv_en;        // master drives the pins
  logic [DATA_W-1:0] last_q = '0;   // last pin level
  logic [1:0]        mode_nxt;      // sleep and order for the next cycle
  // released pins show the inverse of their last level, never a stale copy
  assign dq_line_o = dq_oe_o ? dq_o : (drv_en ? drv_d : ~last_q);
  // remember the pin level each cycle
  always @(posedge core_clk_i) begin
    last_q <= dq_line_o;
  end
  // idle bus at time zero: deselected, output enable high, linear order
  initial begin
    addr_o = '0;
    strb_o = 3'b111;
    sel_o = 3'b101;
    wr_o = 6'h3f;
    mode_o = 3'b100;
    mode_nxt = 2'b00;
    drv_d = '0;
    drv_en = 1'b0;
  end
  // the strap is only moved while the part is deselected
  task automatic set_mode(input logic sleep, input logic order);
    mode_nxt = {sleep, order};
  endtask
  // one bus cycle: launched at the falling edge, held past the rising edge
  task automatic cyc(input logic [2:0] strb, input logic [2:0] sel, input logic [5:0] wr,
                     input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d, input logic oe_n);
    @(negedge core_clk_i);
    strb_o = strb;
    sel_o = sel;
    wr_o = wr;
    addr_o = a;
    mode_o = {oe_n, mode_nxt};
    drv_d = d;
    // data goes out only beside active write controls
    drv_en = (wr[5:4] != 2'b11);
    @(posedge core_clk_i);
    #1;
  endtask
endmodule

// [test/test_pbsp_port.sv]
// self-checking bench for the pipelined burst sram port, write fifo seen through the top
`timescale 1ns/1ns
module test_pbsp_port;
  import pbsp_pkg::*;
  localparam logic [2:0] SEL_ON = 3'b010;  // all three selects active
  localparam logic [5:0] WR_OFF = 6'h3f;   // no write control active
  logic              core_clk_i;           // bench clock
  logic              reset_i;              // bench reset
  logic [ADDR_W-1:0] addr;                 // bus from the master model
  logic [2:0]        strb, sel, mode;
  logic [5:0]        wr;
  logic [DATA_W-1:0] dq_o, dq_line;        // data pins
  logic              dq_oe_o;
  int                mismatches;
  int                comparisons;
  logic [DATA_W-1:0] mem [int];            // reference array
  logic [ADDR_W-1:0] base;                 // burst block under test
  logic [DATA_W-1:0] d;
  logic [5:0]        w;
  pbsp_bus_model pm_u (.core_clk_i(core_clk_i), .dq_o(dq_o), .dq_oe_o(dq_oe_o),
    .addr_o(addr), .strb_o(strb), .sel_o(sel), .wr_o(wr), .mode_o(mode), .dq_line_o(dq_line));
  pbsp_port dut_u (.core_clk_i(core_clk_i), .reset_i(reset_i), .addr_i(addr),
    .proc_addr_strobe_n_i(strb[2]), .ctrl_addr_strobe_n_i(strb[1]), .burst_step_n_i(strb[0]),
    .chip_sel_first_n_i(sel[2]), .chip_sel_second_i(sel[1]), .chip_sel_third_n_i(sel[0]),
    .all_bytes_write_n_i(wr[5]), .byte_write_en_n_i(wr[4]), .byte_lane_sel_n_i(wr[3:0]),
    .out_en_n_i(mode[2]), .sleep_req_i(mode[1]), .burst_order_i(mode[0]),
    .dq_i(dq_line), .dq_o(dq_o), .dq_oe_o(dq_oe_o));
  // verdict and end of run
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // compare a data word
  task automatic chk_data(input logic [DATA_W-1:0] exp, input logic [DATA_W-1:0] got);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR t=%0t data got %h exp %h", $time, got, exp);
    end
  endtask
  // compare a one-bit flag
  task automatic chk_flag(input logic exp, input logic got);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR t=%0t flag got %h exp %h", $time, got, exp);
    end
  endtask
  // burst position k of a burst starting at s
  function automatic logic [1:0] pos(input logic [1:0] s, input int k, input logic o);
    return o ? (s ^ k[1:0]) : (s + k[1:0]);
  endfunction
  // reference write: all bytes on global write, else the low lanes under byte enable
  task automatic mwrite(input int a, input logic [5:0] wc, input logic [DATA_W-1:0] v);
    for (int b = 0; b < LANES; b++) begin
      if (!wc[5] || (!wc[4] && !wc[b])) begin
        mem[a][8*b +: 8] = v[8*b +: 8];
      end
    end
  endtask
  // ctrl strobe with the second select inactive deselects
  task automatic desel();
    pm_u.cyc(3'b101, 3'b000, WR_OFF, '0, '0, 1'b1);
  endtask
  // continuation cycle
  task automatic cont(input logic step_n, input logic oe_n);
    pm_u.cyc({2'b11, step_n}, SEL_ON, WR_OFF, '0, '0, oe_n);
  endtask
  task automatic end_test(input string n);
    $display("test %0s finished", n);
  endtask
  // 20 MHz clock
  initial begin
    core_clk_i = 1'b0;
    forever #25 core_clk_i = ~core_clk_i;
  end
  // watchdog, far beyond the hundred or so cycles the run needs
  initial begin
    #200000;
    mismatches++;
    stop_test();
  end
  // main sequence
  initial begin
    reset_i = 1'b1;
    mismatches = 0;
    comparisons = 0;
    void'($urandom(32'hbee7));
    repeat (2) @(posedge core_clk_i);
    @(negedge core_clk_i);
    reset_i = 1'b0;
    base = 16'($urandom) & 16'hfffc;
    // full words, byte writes, then a byte enable high that must not write
    for (int i = 0; i < 9; i++) begin
      d = $urandom;
      w = (i < 4) ? {1'b0, 5'($urandom)} : (i < 8) ? {2'b10, 4'($urandom)} : 6'h30;
      pm_u.cyc(3'b101, SEL_ON, w, base + 16'(i % 4), d, 1'b1);
      mwrite(int'(base) + i % 4, w, d);
    end
    // processor write: first cycle ignores write controls and advance
    pm_u.cyc(3'b010, SEL_ON, 6'h00, base + 16'd2, '0, 1'b1);
    d = $urandom;
    // at least one lane selected, so the second cycle really is a write
    w = {2'b10, 4'($urandom) & 4'h7};
    fork
      pm_u.cyc(3'b111, SEL_ON, w, '0, d, 1'b0);
      begin
        // inside the write cycle: held read data must float although enable is low
        @(negedge core_clk_i);
        #1;
        chk_flag(1'b0, dq_oe_o);
      end
    join
    chk_flag(1'b0, dq_oe_o);
    mwrite(int'(base) + 2, w, d);
    // both strobes low: processor strobe wins, so this is a read
    pm_u.cyc(3'b000, SEL_ON, 6'h00, base + 16'd1, $urandom, 1'b1);
    chk_data(mem[int'(base) + 1], dq_o);
    end_test("writes");
    for (int o = 0; o < 2; o++) begin
      for (int s = 0; s < 4; s++) begin
        pm_u.set_mode(1'b0, 1'(o));
        desel();
        pm_u.cyc((s % 2) ? 3'b101 : 3'b011, SEL_ON, WR_OFF, base | 16'(s), '0, 1'b0);
        chk_flag(1'b0, dq_oe_o);
        chk_data(mem[int'(base) | s], dq_o);
        for (int k = 1; k < 5; k++) begin
          cont(1'b0, 1'b0);
          chk_flag(1'b1, dq_oe_o);
          chk_data(mem[int'(base) | pos(2'(s), k, 1'(o))], dq_o);
        end
        cont(1'b1, 1'b1);
        chk_flag(1'b0, dq_oe_o);
        chk_data(mem[int'(base) | s], dq_o);
      end
    end
    end_test("bursts");
    // sleep freezes the burst in interleaved order
    desel();
    pm_u.cyc(3'b011, SEL_ON, WR_OFF, base, '0, 1'b0);
    cont(1'b0, 1'b0);
    pm_u.set_mode(1'b1, 1'b1);
    repeat (2) begin
      cont(1'b0, 1'b0);
      chk_flag(1'b0, dq_oe_o);
      chk_data(mem[int'(base) | 1], dq_o);
    end
    pm_u.set_mode(1'b0, 1'b1);
    cont(1'b0, 1'b0);
    chk_data(mem[int'(base) | 2], dq_o);
    end_test("sleep");
    // each select inactive beside a controller strobe deselects
    for (int k = 0; k < 3; k++) begin
      desel();
      pm_u.cyc(3'b011, SEL_ON, WR_OFF, base, '0, 1'b0);
      cont(1'b1, 1'b0);
      chk_flag(1'b1, dq_oe_o);
      pm_u.cyc(3'b101, SEL_ON ^ 3'(1 << k), WR_OFF, base, '0, 1'b0);
      chk_flag(1'b0, dq_oe_o);
    end
    // processor strobe with the first select high leaves the held read alone
    desel();
    pm_u.cyc(3'b011, SEL_ON, WR_OFF, base, '0, 1'b0);
    pm_u.cyc(3'b011, 3'b110, WR_OFF, base + 16'd1, '0, 1'b0);
    chk_flag(1'b1, dq_oe_o);
    chk_data(mem[int'(base)], dq_o);
    end_test("selects");
    // reset in mid-run clears the outputs
    @(negedge core_clk_i);
    reset_i = 1'b1;
    #1;
    chk_flag(1'b0, dq_oe_o);
    chk_data(DATA_RST, dq_o);
    @(negedge core_clk_i);
    reset_i = 1'b0;
    // two back-to-back byte writes, then reads that hit the fifo head and the array
    for (int i = 0; i < 4; i++) begin
      for (int j = 0; j < 2; j++) begin
        d = $urandom;
        w = {2'b10, 4'($urandom)};
        pm_u.cyc(3'b101, SEL_ON, w, base + 16'((i + j) % 4), d, 1'b1);
        mwrite(int'(base) + (i + j) % 4, w, d);
      end
      for (int j = 0; j < 3; j++) begin
        pm_u.cyc(3'b101, SEL_ON, WR_OFF, base + 16'((i + j % 2) % 4), '0, 1'b0);
        chk_flag(1'b1, dq_oe_o);
        chk_data(mem[int'(base) + (i + j % 2) % 4], dq_o);
      end
    end
    end_test("forward");
    stop_test();
  end
endmodule
